// *** design/nand_copyback_defines.svh ***
/*
 * constants for the copyback and column-change command sequencer
 * assumes inclusion by bare name from design files
 */
`ifndef NAND_COPYBACK_DEFINES_SVH
`define NAND_COPYBACK_DEFINES_SVH

// opcodes seen on the command cycles
`define OP_READ 8'h00
`define OP_READ_CONFIRM 8'h30
`define OP_COPYBACK_READ 8'h35
`define OP_PROGRAM 8'h80
`define OP_PARTIAL_PROGRAM 8'h85
`define OP_PROGRAM_CONFIRM 8'h10
`define OP_FLUSH 8'h11
`define OP_COLUMN_CHANGE 8'h05
`define OP_COLUMN_ENHANCED 8'h06
`define OP_COLUMN_CONFIRM 8'hE0
`define OP_STATUS_ENHANCED 8'h78
`define OP_STATUS 8'h70

// geometry
`define PAGE_BYTES 4096
`define COLUMN_BITS 12
`define UNIT_COUNT 2
`define UNIT_SHIFT 7

// array times in ns and cycles at 5 ns
`define CLOCK_PERIOD_NS 5
`define ARRAY_READ_NS 200
`define ARRAY_READ_CYCLES ((`ARRAY_READ_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define ARRAY_PROGRAM_NS 1000
`define ARRAY_PROGRAM_CYCLES ((`ARRAY_PROGRAM_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define FLUSH_CYCLES 4

`endif

// *** design/nand_copyback_pkg.sv ***
/*
 * types for the copyback sequencer
 * assumes the defines header is compiled alongside
 */
package nand_copyback_pkg;
  // command decoder states
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_addr = 4'b0001,
    st_wait_confirm = 4'b0010,
    st_array_busy = 4'b0011,
    st_data_out = 4'b0100,
    st_data_in = 4'b0101,
    st_col_addr = 4'b0110,
    st_col_confirm = 4'b0111,
    st_flush = 4'b1000,
    st_status = 4'b1001
  } seq_state_t;

  // what the current address phase belongs to
  typedef enum logic [2:0] {
    op_read = 3'b000,
    op_program = 3'b001,
    op_col = 3'b010,
    op_col_enh = 3'b011,
    op_status = 3'b100
  } op_kind_t;
endpackage

// *** design/page_buffer.sv ***
/*
 * page register of one unit: one read and one write port
 * assumes synchronous single-clock access
 */
`timescale 1ns/1ps
`include "nand_copyback_defines.svh"

module page_buffer (
  // clock
  input wire logic i_clock,
  // write port
  input wire logic i_write,
  input wire logic [`COLUMN_BITS-1:0] i_write_column,
  input wire logic [7:0] i_write_data,
  // read port
  input wire logic [`COLUMN_BITS-1:0] i_read_column,
  output logic [7:0] o_read_data
);
  // the single store used by both halves of a copyback
  logic [7:0] store [0:`PAGE_BYTES-1];

  // write and registered read
  always_ff @(posedge i_clock) begin
    if (i_write) begin
      store[i_write_column] <= i_write_data;
    end
    o_read_data <= store[i_read_column];
  end
endmodule

// *** design/nand_copyback_seq.sv ***
/*
 * command sequencer for copyback, small data moves and read column changes
 * assumes host keeps to command ordering and the column-change setup time
 */
`timescale 1ns/1ps
`include "nand_copyback_defines.svh"

module nand_copyback_seq (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // host bus cycles
  input wire logic i_command_valid,
  input wire logic i_address_valid,
  input wire logic i_write_valid,
  input wire logic i_read_strobe,
  input wire logic [7:0] i_bus,
  // data output
  output logic [7:0] o_read_data,
  output logic o_read_valid,
  output logic o_output_enable_n,
  // status
  output logic [7:0] o_status,
  // array model interface
  output logic o_array_read,
  output logic o_array_program,
  output logic [23:0] o_array_row
);
  // ************************************************
  // state
  // ************************************************
  nand_copyback_pkg::seq_state_t state; // decoder state
  nand_copyback_pkg::op_kind_t kind; // owner of address phase
  logic [2:0] addr_count; // address cycles taken
  logic [2:0] addr_need; // address cycles expected
  logic [39:0] addr_shift; // collected address, lsb first
  logic [`COLUMN_BITS-1:0] read_column; // output pointer
  logic [`COLUMN_BITS-1:0] write_column; // input pointer
  logic [23:0] row; // current row
  logic [15:0] busy_count; // array timer
  logic in_read_idle; // page holds read data
  logic selected; // this target drives output
  logic [`COLUMN_BITS-1:0] next_column;
  logic [7:0] buffer_data;
  logic buffer_write;
  logic unit_ready_bit;
  logic starting_busy; // a busy-making command is taken this cycle

  // status byte: bit 6 is ready, bit 7 not protected
  assign unit_ready_bit = (state != nand_copyback_pkg::st_array_busy) &&
                          (state != nand_copyback_pkg::st_flush);
  assign o_status = {1'b1, unit_ready_bit, unit_ready_bit, 5'h00};
  // busy begins at the edge that takes the command, so the registered enable must see it early
  assign starting_busy = i_command_valid && unit_ready_bit &&
                         (i_bus == `OP_READ_CONFIRM || i_bus == `OP_COPYBACK_READ ||
                          i_bus == `OP_PROGRAM_CONFIRM || i_bus == `OP_FLUSH);
  assign next_column = addr_shift[`COLUMN_BITS-1:0];
  assign buffer_write = i_write_valid && (state == nand_copyback_pkg::st_data_in);
  assign o_array_row = row;

  // ************************************************
  // page register
  // ************************************************
  // one buffer serves both halves, so copyback keeps data in place
  page_buffer u_page (
    .i_clock(i_clock),
    .i_write(buffer_write),
    .i_write_column(write_column),
    .i_write_data(i_bus),
    .i_read_column(read_column),
    .o_read_data(buffer_data)
  );

  // ************************************************
  // command decoder
  // ************************************************
  // address cycles assemble lsb first; column is bytes 0-1, row 2-4
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      addr_shift <= 40'h0000000000;
      addr_count <= 3'h0;
    end else if (i_command_valid) begin
      addr_count <= 3'h0;
    end else if (i_address_valid) begin
      addr_shift[addr_count*8 +: 8] <= i_bus;
      addr_count <= addr_count + 3'h1;
    end
  end

  // main sequencer
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state <= nand_copyback_pkg::st_idle;
      kind <= nand_copyback_pkg::op_read;
      addr_need <= 3'h5;
      busy_count <= 16'h0000;
      o_array_read <= 1'b0;
      o_array_program <= 1'b0;
    end else begin
      o_array_read <= 1'b0;
      o_array_program <= 1'b0;
      if (state == nand_copyback_pkg::st_array_busy || state == nand_copyback_pkg::st_flush) begin
        // busy: all commands, status included, are ignored
        if (busy_count != 16'h0000) begin
          busy_count <= busy_count - 16'h0001;
        end else begin
          state <= in_read_idle ? nand_copyback_pkg::st_data_out : nand_copyback_pkg::st_idle;
        end
      end else if (i_command_valid) begin
        case (i_bus)
          `OP_READ: begin
            // plain read, copyback read, or row set for random data out
            kind <= nand_copyback_pkg::op_read;
            addr_need <= 3'h5;
            state <= nand_copyback_pkg::st_addr;
          end
          `OP_READ_CONFIRM, `OP_COPYBACK_READ: begin
            o_array_read <= 1'b1;
            busy_count <= 16'(`ARRAY_READ_CYCLES);
            state <= nand_copyback_pkg::st_array_busy;
          end
          `OP_PROGRAM, `OP_PARTIAL_PROGRAM: begin
            // 85h keeps page contents; data in may follow
            kind <= nand_copyback_pkg::op_program;
            addr_need <= 3'h5;
            state <= nand_copyback_pkg::st_addr;
          end
          `OP_PROGRAM_CONFIRM: begin
            o_array_program <= 1'b1;
            busy_count <= 16'(`ARRAY_PROGRAM_CYCLES);
            state <= nand_copyback_pkg::st_array_busy;
          end
          `OP_FLUSH: begin
            busy_count <= 16'(`FLUSH_CYCLES);
            state <= nand_copyback_pkg::st_flush;
          end
          `OP_COLUMN_CHANGE: begin
            kind <= nand_copyback_pkg::op_col;
            addr_need <= 3'h2;
            state <= nand_copyback_pkg::st_col_addr;
          end
          `OP_COLUMN_ENHANCED: begin
            kind <= nand_copyback_pkg::op_col_enh;
            addr_need <= 3'h5;
            state <= nand_copyback_pkg::st_col_addr;
          end
          `OP_COLUMN_CONFIRM: begin
            state <= nand_copyback_pkg::st_data_out;
          end
          `OP_STATUS_ENHANCED: begin
            kind <= nand_copyback_pkg::op_status;
            addr_need <= 3'h3;
            state <= nand_copyback_pkg::st_addr;
          end
          `OP_STATUS: begin
            state <= nand_copyback_pkg::st_status;
          end
          default: begin
            state <= nand_copyback_pkg::st_idle;
          end
        endcase
      end else if (i_address_valid && (addr_count + 3'h1 == addr_need)) begin
        // last address cycle closes the phase
        if (kind == nand_copyback_pkg::op_program) begin
          state <= nand_copyback_pkg::st_data_in;
        end else if (kind == nand_copyback_pkg::op_status) begin
          state <= nand_copyback_pkg::st_status;
        end else if (state == nand_copyback_pkg::st_col_addr) begin
          state <= nand_copyback_pkg::st_col_confirm;
        end else begin
          state <= nand_copyback_pkg::st_wait_confirm;
        end
      end
    end
  end

  // ************************************************
  // pointers and row
  // ************************************************
  // column pointers load on the last address cycle, advance per byte
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      read_column <= 12'h000;
      write_column <= 12'h000;
      row <= 24'h000000;
    end else if (i_address_valid && (addr_count + 3'h1 == addr_need)) begin
      if (kind == nand_copyback_pkg::op_program) begin
        write_column <= next_column;
        row <= {i_bus, addr_shift[31:16]};
      end else if (kind == nand_copyback_pkg::op_col) begin
        read_column <= {i_bus[3:0], addr_shift[7:0]};
      end else if (kind == nand_copyback_pkg::op_col_enh && !i_bus[`UNIT_SHIFT]) begin
        // another unit's address leaves this pointer and row alone
        read_column <= next_column;
        row <= {i_bus, addr_shift[31:16]};
      end else if (kind == nand_copyback_pkg::op_read) begin
        // column cycles also load the read pointer when used as random data out row set
        read_column <= next_column;
        row <= {i_bus, addr_shift[31:16]};
      end
    end else begin
      if (buffer_write) begin
        write_column <= write_column + 12'h001;
      end
      if (i_read_strobe && state == nand_copyback_pkg::st_data_out) begin
        read_column <= read_column + 12'h001;
      end
    end
  end

  // page data valid for output after a read completes
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      in_read_idle <= 1'b0;
    end else if (o_array_read) begin
      in_read_idle <= 1'b1;
    end else if (o_array_program) begin
      in_read_idle <= 1'b0;
    end
  end

  // ************************************************
  // output drivers
  // ************************************************
  // enhanced change to another unit releases drivers while idle;
  // a 78h status read re-selects using the unit field of its row
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      selected <= 1'b1;
    end else if (i_address_valid && (addr_count + 3'h1 == addr_need) &&
                 (kind == nand_copyback_pkg::op_col_enh || kind == nand_copyback_pkg::op_status)) begin
      selected <= (i_bus[`UNIT_SHIFT] == 1'b0);
    end
  end

  // registered data out; flush leaves output quiet until done
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_read_data <= 8'h00;
      o_read_valid <= 1'b0;
      o_output_enable_n <= 1'b1;
    end else begin
      o_read_valid <= i_read_strobe && selected &&
                      (state == nand_copyback_pkg::st_data_out || state == nand_copyback_pkg::st_status);
      o_output_enable_n <= !(selected && unit_ready_bit && !starting_busy);
      o_read_data <= (state == nand_copyback_pkg::st_status) ? o_status : buffer_data;
    end
  end
endmodule

// *** verif/nand_copyback_properties.sv ***
/* port relations of the copyback sequencer
   assumes it is bound onto nand_copyback_seq */
`timescale 1ns/1ps
module nand_copyback_properties (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // host cycles
  input wire logic i_command_valid,
  input wire logic i_read_strobe,
  input wire logic [7:0] i_bus,
  // answers
  input wire logic o_read_valid,
  input wire logic o_output_enable_n,
  input wire logic [7:0] o_status,
  input wire logic o_array_read,
  input wire logic o_array_program
);
  // ********
  // checks
  // ********
  // one domain, so clock and reset are given once
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  chk_status_fixed: assert property (o_status[7] && o_status[4:0] == 5'h00)
    else $error("status fixed bits wrong");
  chk_ready_pair: assert property (o_status[6] == o_status[5])
    else $error("ready bits differ");
  chk_read_cause: assert property (o_array_read |->
    $past(i_command_valid) && ($past(i_bus) == 8'h35 || $past(i_bus) == 8'h30))
    else $error("array read without its confirm");
  chk_read_busy: assert property ($rose(o_array_read) |=> !o_status[6] [*8])
    else $error("ready during array read");
  chk_prog_cause: assert property (o_array_program |->
    $past(i_command_valid) && $past(i_bus) == 8'h10)
    else $error("program without confirm");
  chk_prog_busy: assert property (o_array_program |=> !o_status[6] [*8])
    else $error("ready during program");
  chk_busy_bound: assert property ($fell(o_status[6]) |-> ##[1:250] o_status[6])
    else $error("busy too long");
  chk_valid_cause: assert property (o_read_valid |-> $past(i_read_strobe))
    else $error("output byte without strobe");
  chk_drive_ready: assert property (!o_output_enable_n |-> o_status[6])
    else $error("driving while busy");
  // main scenarios reached
  cov_read: cover property (o_array_read);
  cov_prog: cover property (o_array_program);
  cov_out: cover property (o_read_valid && !o_output_enable_n);
endmodule

bind nand_copyback_seq nand_copyback_properties u_nand_copyback_properties (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_command_valid(i_command_valid),
  .i_read_strobe(i_read_strobe), .i_bus(i_bus), .o_read_valid(o_read_valid),
  .o_output_enable_n(o_output_enable_n), .o_status(o_status),
  .o_array_read(o_array_read), .o_array_program(o_array_program));

// *** verif/flash_host.sv ***
/* host controller model: command, address and data cycles
   assumes the sequencer samples on the rising edge */
`timescale 1ns/1ps
module flash_host (
  // clock
  input wire logic i_clock,
  // answers
  input wire logic [7:0] i_read_data,
  input wire logic i_read_valid,
  input wire logic [7:0] i_status,
  // bus cycles
  output logic o_command_valid,
  output logic o_address_valid,
  output logic o_write_valid,
  output logic o_read_strobe,
  output logic [7:0] o_bus
);
  // ********
  // cycles
  // ********
  initial begin
    {o_command_valid, o_address_valid, o_write_valid, o_read_strobe} = 4'h0;
    o_bus = 8'h00;
  end
  // k: 0 command, 1 address, 2 data in
  task automatic cyc(input int k, input logic [7:0] b);
    @(negedge i_clock);
    o_bus = b;
    {o_command_valid, o_address_valid, o_write_valid} = {k == 0, k == 1, k == 2};
    @(negedge i_clock);
    {o_command_valid, o_address_valid, o_write_valid} = 3'h0;
    o_bus = ~b; // released bus never shows the stale byte
  endtask
  // low byte first, row after column
  task automatic addr5(input logic [11:0] c, input logic [23:0] r);
    cyc(1, c[7:0]);
    cyc(1, {4'h0, c[11:8]});
    cyc(1, r[7:0]);
    cyc(1, r[15:8]);
    cyc(1, r[23:16]);
  endtask
  // plain column change, then setup time before output
  task automatic col_change(input logic [11:0] c);
    cyc(0, 8'h05);
    cyc(1, c[7:0]);
    cyc(1, {4'h0, c[11:8]});
    cyc(0, 8'hE0);
    repeat (4) @(negedge i_clock);
  endtask
  // enhanced change, only after array reads
  task automatic enh(input logic [11:0] c, input logic [23:0] r);
    cyc(0, 8'h06);
    addr5(c, r);
    cyc(0, 8'hE0);
    repeat (4) @(negedge i_clock);
  endtask
  // status select by row: unit bit in the third cycle, then settle
  task automatic stat_sel(input logic [23:0] r);
    cyc(0, 8'h78);
    cyc(1, r[7:0]);
    cyc(1, r[15:8]);
    cyc(1, r[23:16]);
    repeat (2) @(negedge i_clock);
  endtask
  // bounded wait for the ready bit
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(negedge i_clock);
      ok = (i_status[6] === 1'b1);
    end
  endtask
  // one output byte: data comes with valid and holds a cycle, taken a cycle later
  task automatic rd(output logic [7:0] d, output bit ok);
    ok = 1'b0;
    @(negedge i_clock);
    o_read_strobe = 1'b1;
    @(negedge i_clock);
    o_read_strobe = 1'b0;
    for (int n = 0; n < 3 && !ok; n++) begin
      ok = (i_read_valid === 1'b1);
      @(negedge i_clock);
    end
    d = i_read_data;
  endtask
endmodule

// *** verif/tb.sv ***
/* self-checking bench for the copyback sequencer
   assumes the host model drives every sequencer input except clock and reset */
`timescale 1ns/1ps
module tb;
  // ********
  // harness
  // ********
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_v, adr_v, wr_v, rd_s, rval, oe_n, aread, aprog;
  logic [7:0] bus, rdat, stat, d;
  logic [23:0] arow;
  bit ok;
  int fail_count = 0;
  int cmp_count = 0;
  // odd source and odd destination, unit 0
  localparam logic [23:0] ROW_A = 24'h012345;
  localparam logic [23:0] ROW_B = 24'h012347;
  localparam logic [7:0] PAT [4] = '{8'h3C, 8'hC3, 8'h5A, 8'hA5};
  always #2.5 clock = ~clock;
  nand_copyback_seq u_nand_copyback_seq (.i_clock(clock), .i_reset_n(reset_n),
    .i_command_valid(cmd_v), .i_address_valid(adr_v), .i_write_valid(wr_v),
    .i_read_strobe(rd_s), .i_bus(bus), .o_read_data(rdat), .o_read_valid(rval),
    .o_output_enable_n(oe_n), .o_status(stat), .o_array_read(aread),
    .o_array_program(aprog), .o_array_row(arow));
  flash_host u_flash_host (.i_clock(clock), .i_read_data(rdat), .i_read_valid(rval),
    .i_status(stat), .o_command_valid(cmd_v), .o_address_valid(adr_v),
    .o_write_valid(wr_v), .o_read_strobe(rd_s), .o_bus(bus));
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk24(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // a wait that ran out ends the run
  task automatic need(input bit k);
    chk8({7'h00, k}, 8'h01);
    if (!k) complete_run();
  endtask
  task automatic complete_run();
    $display("mismatches %0d of %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ***********
  // scenarios
  // ***********
  task automatic sc_reset();
    chk8(stat, 8'hE0);
    chk8({6'h00, oe_n, rval}, 8'h02);
  endtask
  task automatic sc_copyback_read();
    u_flash_host.cyc(0, 8'h00);
    u_flash_host.addr5(12'h000, ROW_A);
    u_flash_host.cyc(0, 8'h35);
    chk8({6'h00, aread, stat[6]}, 8'h02);
    u_flash_host.wait_ready(ok);
    need(ok);
    chk24(arow, ROW_A);
  endtask
  // partial load at the page top, flush, read back
  task automatic sc_partial();
    u_flash_host.cyc(0, 8'h85);
    u_flash_host.addr5(12'hFFC, ROW_B);
    for (int i = 0; i < 4; i++) u_flash_host.cyc(2, PAT[i]);
    u_flash_host.cyc(0, 8'h11);
    u_flash_host.wait_ready(ok);
    need(ok);
    u_flash_host.col_change(12'hFFC);
    chk8({7'h00, oe_n}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_flash_host.rd(d, ok);
      need(ok);
      chk8(d, PAT[i]);
    end
  endtask
  // other unit lets go of the bus, own unit redirects
  task automatic sc_enhanced();
    u_flash_host.enh(12'h000, ROW_A | 24'h800000);
    chk8({7'h00, oe_n}, 8'h01);
    chk24(arow, ROW_B);
    u_flash_host.enh(12'hFFE, ROW_A);
    chk24(arow, ROW_A);
    u_flash_host.rd(d, ok);
    need(ok);
    chk8(d, PAT[2]);
  endtask
  task automatic sc_program();
    u_flash_host.cyc(0, 8'h85);
    u_flash_host.addr5(12'hFFF, ROW_B);
    u_flash_host.cyc(2, 8'h77);
    u_flash_host.cyc(0, 8'h10);
    chk8({6'h00, aprog, stat[6]}, 8'h02);
    chk24(arow, ROW_B);
    u_flash_host.wait_ready(ok);
    need(ok);
  endtask
  // status select releases the other unit, own unit answers
  task automatic sc_status();
    u_flash_host.stat_sel(ROW_A | 24'h800000);
    chk8({7'h00, oe_n}, 8'h01);
    u_flash_host.stat_sel(ROW_A);
    chk8({7'h00, oe_n}, 8'h00);
    u_flash_host.rd(d, ok);
    need(ok);
    chk8(d, 8'hE0);
    u_flash_host.cyc(0, 8'h70);
    u_flash_host.rd(d, ok);
    need(ok);
    chk8(d, 8'hE0);
  endtask
  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    sc_reset();
    sc_copyback_read();
    sc_partial();
    sc_enhanced();
    sc_program();
    sc_status();
    complete_run();
  end
endmodule
